// ==== hw/pofs_pkg.sv ====
// Purpose: constants, types and reset state of the on/off, protect and status block
// Assumes: one byte-wide command port fed by bus framing logic on the same clock
package pofs_pkg;
   localparam logic [7:0] CODE_OPERATION = 8'h01;
   localparam logic [7:0] CODE_ONOFF_CFG = 8'h02;
   localparam logic [7:0] CODE_CLEAR     = 8'h03;
   localparam logic [7:0] CODE_PROTECT   = 8'h10;
   localparam logic [7:0] CODE_STORE     = 8'h11;
   localparam logic [7:0] CODE_RESTORE   = 8'h12;
   localparam logic [7:0] CODE_STAT_LOW  = 8'h78;
   localparam logic [7:0] CODE_STAT_WORD = 8'h79;
   localparam logic [7:0] CODE_CUST_FIRST = 8'hd0;
   localparam logic [7:0] CODE_CUST_LAST  = 8'hd6;
   localparam int         OP_ON_BIT      = 7;
   localparam int         CFG_CMD_BIT    = 3;
   localparam int         CFG_PIN_BIT    = 2;
   localparam logic [7:0] CFG_FIXED_ONES = 8'h13;
   localparam int         WP_ONLY_PROT   = 7;
   localparam int         WP_PLUS_OP     = 6;
   localparam int         WP_PLUS_CFG    = 5;
   localparam logic       CMD_SEL_RST    = 1'b0;
   localparam logic       PIN_SEL_RST    = 1'b1;
   localparam logic       OP_ON_RST      = 1'b0;
   localparam logic [7:0] WP_RST         = 8'h00;
   localparam int         SY_EN          = 5;
   localparam int         SY_PG          = 6;
   localparam int         SY_ADDR        = 7;
   localparam int         CLK_HZ         = 20_000_000;
   localparam int         NVM_COPY_US    = 100;
   localparam int         NVM_COPY_CYC   = NVM_COPY_US * (CLK_HZ / 1_000_000);
   localparam int         CNT_W          = 12;

   typedef enum logic [1:0] {
      POFS_IDLE    = 2'b00,
      POFS_STORE   = 2'b01,
      POFS_RESTORE = 2'b10
   } pofs_state_t;

   typedef struct packed {
      logic       valid;
      logic       write;
      logic [7:0] code;
      logic [7:0] data;
   } pofs_cmd_t;

   typedef struct packed {
      logic        valid;
      logic        busy;
      logic [15:0] data;
   } pofs_rsp_t;

   typedef struct packed {
      logic [7:0]       sa;
      logic [7:0]       sb;
      pofs_state_t      st;
      logic [CNT_W-1:0] cnt;
      logic             op_on;
      logic             cmd_sel;
      logic             pin_sel;
      logic             nvm_cmd;
      logic             nvm_pin;
      logic [7:0]       wp;
      logic [4:0]       flags_lo;
      logic [2:0]       flags_hi;
      logic             latch_off;
      logic             en_q;
      logic             rvalid;
      logic [15:0]      rdata;
   } pofs_regs_t;

   localparam pofs_regs_t REGS_RST = '{st: POFS_IDLE, op_on: OP_ON_RST,
      cmd_sel: CMD_SEL_RST, nvm_cmd: CMD_SEL_RST, pin_sel: PIN_SEL_RST,
      nvm_pin: PIN_SEL_RST, wp: WP_RST, default: '0};
endpackage

// ==== hw/pofs_top.sv ====
// Purpose: on/off source select, write protect, fault flags, store/restore, status
// Assumes: pins pass two flops; command port is on clk
// Notes: alert is open drain, driven low while any flag is set
`timescale 1ns/1ps
module pofs_top (
   // clock and reset
   input  wire logic                clk,
   input  wire logic                nrst,
   // command port
   input  wire pofs_pkg::pofs_cmd_t cmd,
   output pofs_pkg::pofs_rsp_t      rsp,
   // pins and analog conditions
   input  wire logic                en_pin,
   input  wire logic                power_good_pin,
   input  wire logic                addr_done,
   input  wire logic [4:0]          fault_cond,
   // converter and alert
   output logic                     conv_enable,
   output logic                     alert_out,
   output logic                     alert_oe_n
);
   pofs_pkg::pofs_regs_t r;
   pofs_pkg::pofs_regs_t next_r;
   logic                 en_s;
   logic                 pg_s;
   logic                 addr_s;
   logic [4:0]           cond;
   logic                 en_req;
   logic                 en_rise;
   logic                 trip;
   logic [7:0]           stat_lo;
   logic [7:0]           stat_hi;
   logic                 idle_cmd;

   function automatic logic wr_ok(input logic [7:0] wp, input logic [7:0] code);
      if (wp[pofs_pkg::WP_ONLY_PROT])
         return code == pofs_pkg::CODE_PROTECT;
      if (wp[pofs_pkg::WP_PLUS_OP])
         return code inside {pofs_pkg::CODE_PROTECT, pofs_pkg::CODE_OPERATION};
      if (wp[pofs_pkg::WP_PLUS_CFG])
         return code inside {pofs_pkg::CODE_PROTECT, pofs_pkg::CODE_OPERATION,
                             pofs_pkg::CODE_ONOFF_CFG};
      return 1'b1;
   endfunction

   assign en_s   = r.sb[pofs_pkg::SY_EN];
   assign pg_s   = r.sb[pofs_pkg::SY_PG];
   assign addr_s = r.sb[pofs_pkg::SY_ADDR];
   assign cond   = r.sb[4:0];
   assign trip   = cond[4] | cond[3] | cond[1];
   assign idle_cmd = cmd.valid && (r.st == pofs_pkg::POFS_IDLE);

   always_comb begin
      case ({r.cmd_sel, r.pin_sel})
         2'b01:   en_req = en_s;
         2'b10:   en_req = r.op_on;
         2'b11:   en_req = r.op_on & en_s;
         default: en_req = addr_s;
      endcase
   end
   assign en_rise = en_req & ~r.en_q;

   assign stat_lo = {1'b0, ~conv_enable, r.flags_lo, 1'b0};
   assign stat_hi = {r.flags_hi, 1'b0, pg_s, 3'b000};

   always_comb begin
      logic clr;
      logic unsup;
      logic fclr;
      clr    = 1'b0;
      unsup  = 1'b0;
      next_r = r;
      next_r.sa = {addr_done, power_good_pin, en_pin, fault_cond};
      next_r.sb = r.sa;
      next_r.rvalid = 1'b0;
      case (r.st)
         pofs_pkg::POFS_IDLE: begin
            if (cmd.valid && cmd.write) begin
               case (cmd.code)
                  pofs_pkg::CODE_OPERATION: begin
                     if (wr_ok(r.wp, cmd.code))
                        next_r.op_on = cmd.data[pofs_pkg::OP_ON_BIT];
                  end
                  pofs_pkg::CODE_ONOFF_CFG: begin
                     if (wr_ok(r.wp, cmd.code)) begin
                        next_r.cmd_sel = cmd.data[pofs_pkg::CFG_CMD_BIT];
                        next_r.pin_sel = cmd.data[pofs_pkg::CFG_PIN_BIT];
                     end
                  end
                  pofs_pkg::CODE_PROTECT: next_r.wp = cmd.data;
                  pofs_pkg::CODE_CLEAR: clr = wr_ok(r.wp, cmd.code);
                  pofs_pkg::CODE_STORE: begin
                     if (wr_ok(r.wp, cmd.code)) begin
                        next_r.st  = pofs_pkg::POFS_STORE;
                        next_r.cnt = pofs_pkg::CNT_W'(pofs_pkg::NVM_COPY_CYC - 1);
                     end
                  end
                  pofs_pkg::CODE_RESTORE: begin
                     if (wr_ok(r.wp, cmd.code)) begin
                        next_r.st  = pofs_pkg::POFS_RESTORE;
                        next_r.cnt = pofs_pkg::CNT_W'(pofs_pkg::NVM_COPY_CYC - 1);
                     end
                  end
                  default: begin
                     unsup = !(cmd.code >= pofs_pkg::CODE_CUST_FIRST &&
                               cmd.code <= pofs_pkg::CODE_CUST_LAST);
                  end
               endcase
            end else if (cmd.valid) begin
               next_r.rvalid = 1'b1;
               case (cmd.code)
                  pofs_pkg::CODE_OPERATION:
                     next_r.rdata = {8'h00, r.op_on, 7'h00};
                  pofs_pkg::CODE_ONOFF_CFG:
                     next_r.rdata = {8'h00, pofs_pkg::CFG_FIXED_ONES | {4'h0, r.cmd_sel,
                                     r.pin_sel, 2'b00}};
                  pofs_pkg::CODE_PROTECT:   next_r.rdata = {8'h00, r.wp};
                  pofs_pkg::CODE_STAT_LOW:  next_r.rdata = {8'h00, stat_lo};
                  pofs_pkg::CODE_STAT_WORD: next_r.rdata = {stat_hi, stat_lo};
                  default: begin
                     next_r.rdata = 16'h0000;
                     unsup = !(cmd.code >= pofs_pkg::CODE_CUST_FIRST &&
                               cmd.code <= pofs_pkg::CODE_CUST_LAST);
                  end
               endcase
            end
         end
         pofs_pkg::POFS_STORE: begin
            if (r.cnt == '0) begin
               next_r.nvm_cmd = r.cmd_sel;
               next_r.nvm_pin = r.pin_sel;
               next_r.st      = pofs_pkg::POFS_IDLE;
            end else begin
               next_r.cnt = r.cnt - 1'b1;
            end
         end
         pofs_pkg::POFS_RESTORE: begin
            if (r.cnt == '0) begin
               next_r.cmd_sel = r.nvm_cmd;
               next_r.pin_sel = r.nvm_pin;
               next_r.st      = pofs_pkg::POFS_IDLE;
            end else begin
               next_r.cnt = r.cnt - 1'b1;
            end
         end
         default: next_r.st = pofs_pkg::POFS_IDLE;
      endcase
      // set wins over clear, so a lasting fault re-latches at once
      fclr = clr | en_rise;
      next_r.flags_lo = (r.flags_lo & ~{5{fclr}}) | cond | {4'h0, unsup};
      next_r.flags_hi = (r.flags_hi & ~{3{fclr}}) | cond[4:2];
      // only off-then-on clears the latch, never the clear command
      next_r.latch_off = (r.latch_off & ~en_rise) | trip;
      next_r.en_q = en_req;
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst)
         r <= pofs_pkg::REGS_RST;
      else
         r <= next_r;
   end

   assign conv_enable = r.en_q & ~r.latch_off;
   assign alert_out   = 1'b0;
   assign alert_oe_n  = ~(|r.flags_lo | |r.flags_hi);
   assign rsp = '{valid: r.rvalid, busy: r.st != pofs_pkg::POFS_IDLE, data: r.rdata};

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);

   a_cfg_fixed_bits: assert property (
      idle_cmd && !cmd.write && cmd.code == pofs_pkg::CODE_ONOFF_CFG
      |=> rsp.valid && rsp.data[7:5] == 3'b000 && rsp.data[4] && rsp.data[1:0] == 2'b11)
      else $error("config read lost its fixed bits");
   a_pin_only_on: assert property (
      !r.cmd_sel && r.pin_sel && en_s && !trip && !r.latch_off |=> conv_enable)
      else $error("pin-only mode did not follow the pin");
   a_bus_only_off: assert property (
      r.cmd_sel && !r.pin_sel && !r.op_on |=> !conv_enable)
      else $error("bus-only mode on without bus bit");
   a_both_need_pin: assert property (
      r.cmd_sel && r.pin_sel && !en_s |=> !conv_enable)
      else $error("both mode on without pin");
   a_auto_enable: assert property (
      !r.cmd_sel && !r.pin_sel && addr_s && !trip && !r.latch_off |=> conv_enable)
      else $error("auto mode did not enable");
   a_protect_blocks: assert property (
      idle_cmd && cmd.write && r.wp[pofs_pkg::WP_ONLY_PROT]
      && cmd.code == pofs_pkg::CODE_ONOFF_CFG |=> $stable(r.cmd_sel) && $stable(r.pin_sel))
      else $error("protected config write took effect");
   a_clear_flags: assert property (
      idle_cmd && cmd.write && cmd.code == pofs_pkg::CODE_CLEAR && r.wp == 8'h00
      && cond == 5'h00 |=> r.flags_lo == 5'h00 && r.flags_hi == 3'h0 && alert_oe_n)
      else $error("clear left flags set");
   a_flag_rearm: assert property (
      cond[4] |=> r.flags_lo[4] && r.flags_hi[2] && !alert_oe_n)
      else $error("present fault not latched");
   a_latch_holds: assert property (
      r.latch_off && r.en_q && en_req |=> r.latch_off [*2])
      else $error("latched-off converter restarted");
   a_byte_is_low: assert property (
      idle_cmd && !cmd.write && cmd.code == pofs_pkg::CODE_STAT_LOW
      |=> rsp.valid && rsp.data == {8'h00, $past(stat_lo)})
      else $error("status byte differs from word low byte");
   a_store_busy: assert property (
      idle_cmd && cmd.write && cmd.code == pofs_pkg::CODE_STORE && r.wp == 8'h00
      |=> rsp.busy [*8])
      else $error("store did not hold the port busy");
endmodule // pofs_top

// ==== dv/pofs_host_model.sv ====
// Purpose: host side of the command port, one read or write per call
// Assumes: bus framing already stripped; waits for busy to drop before a request
// Notes: fields not qualified by valid show the inverse of their last value
`timescale 1ns/1ps
module pofs_host_model (
   // clock
   input  wire logic                clk,
   // command port
   output pofs_pkg::pofs_cmd_t      cmd,
   input  wire pofs_pkg::pofs_rsp_t rsp
);
   int n_store = 0;

   initial cmd = '0;

   task automatic xfer(input logic w, input logic [7:0] c, input logic [7:0] d,
                       output logic [15:0] q);
      int n;
      n = 0;
      q = '0;
      @(posedge clk);
      #1;
      while (rsp.busy !== 1'b0 && n < 5000) begin
         @(posedge clk);
         #1;
         n++;
      end
      // limited wear of the non-volatile cells
      if (w && c == 8'h11) begin
         if (n_store >= 1000) return;
         n_store++;
      end
      cmd = '{1'b1, w, c, d};
      @(posedge clk);
      #1;
      if (!w) q = (rsp.valid === 1'b1) ? rsp.data : 16'hxxxx;
      cmd = '{1'b0, ~w, ~c, ~d};
   endtask
endmodule // pofs_host_model

// ==== dv/test_pmbus_onoff_protect_fault_status.sv ====
// Purpose: self-checking bench for the on/off, protect and status block
// Assumes: host model drives the command port; pins driven after clock edge
// Notes: expected status built from the fault inputs, never from outputs
`timescale 1ns/1ps
module test_pmbus_onoff_protect_fault_status;
   logic                clk;
   logic                nrst;
   pofs_pkg::pofs_cmd_t cmd;
   pofs_pkg::pofs_rsp_t rsp;
   logic                en_pin;
   logic                power_good_pin;
   logic                addr_done;
   logic [4:0]          fault_cond;
   logic                conv_enable;
   logic                alert_out;
   logic                alert_oe_n;
   logic                ex;
   logic [15:0]         w;
   logic [7:0]          wps [4] = '{8'h80, 8'h40, 8'h20, 8'h00};
   int                  n_mismatch = 0;
   int                  check_count = 0;

   pofs_top i_dut (.clk(clk), .nrst(nrst), .cmd(cmd), .rsp(rsp), .en_pin(en_pin),
      .power_good_pin(power_good_pin), .addr_done(addr_done), .fault_cond(fault_cond),
      .conv_enable(conv_enable), .alert_out(alert_out), .alert_oe_n(alert_oe_n));
   pofs_host_model i_host (.clk(clk), .cmd(cmd), .rsp(rsp));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task automatic check(input string s, input logic [15:0] seen, input logic [15:0] e);
      check_count++;
      if (seen !== e) begin
         n_mismatch++;
         $display("unexpected %s expected %h seen %h", s, e, seen);
      end
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic wr(input logic [7:0] c, input logic [7:0] d);
      logic [15:0] q;
      i_host.xfer(1'b1, c, d, q);
   endtask

   task automatic rd(input logic [7:0] c, input logic [15:0] e, input string s);
      logic [15:0] q;
      i_host.xfer(1'b0, c, 8'h00, q);
      check(s, q, e);
   endtask

   // status word from latched flags, power good pin and converter state
   function automatic logic [15:0] stat(input logic [4:0] f, input logic on);
      return {f[4], f[3], f[2], 1'b0, power_good_pin, 3'b000, 1'b0, ~on, f, 1'b0};
   endfunction

   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      print_verdict();
   end

   initial begin
      nrst = 1'b0;
      en_pin = 1'b0;
      power_good_pin = 1'b1;
      addr_done = 1'b1;
      fault_cond = 5'h00;
      idle(12);
      nrst = 1'b1;
      rd(8'h02, 16'h0017, "config");
      rd(8'h10, 16'h0000, "protect");
      wr(8'h02, 8'hff);
      rd(8'h02, 16'h001f, "config");
      for (int i = 0; i < 16; i++) begin
         wr(8'h02, {4'h0, i[3:2], 2'b00});
         wr(8'h01, {i[1], 7'h00});
         en_pin = i[0];
         idle(5);
         case (i[3:2])
            2'b01: ex = i[0];
            2'b10: ex = i[1];
            2'b11: ex = i[0] & i[1];
            default: ex = 1'b1;
         endcase
         check("conv_enable", {15'h0, conv_enable}, {15'h0, ex});
      end
      for (int k = 0; k < 4; k++) begin
         wr(8'h10, 8'h00);
         wr(8'h01, 8'h00);
         wr(8'h02, 8'h04);
         wr(8'h10, wps[k]);
         wr(8'h01, 8'h80);
         wr(8'h02, 8'h08);
         rd(8'h10, {8'h00, wps[k]}, "protect");
         rd(8'h01, (k > 0) ? 16'h0080 : 16'h0000, "operation");
         rd(8'h02, (k < 2) ? 16'h0017 : 16'h001b, "config");
      end
      wr(8'h10, 8'h00);
      wr(8'h02, 8'h04);
      idle(5);
      fault_cond = 5'b00100;
      idle(5);
      w = stat(5'b00100, 1'b1);
      rd(8'h79, w, "word");
      check("alert", {15'h0, alert_oe_n}, 16'h0000);
      fault_cond = 5'h00;
      idle(5);
      rd(8'h79, w, "word");
      rd(8'h78, {8'h00, w[7:0]}, "byte");
      wr(8'h03, 8'h00);
      idle(2);
      rd(8'h79, stat(5'h00, 1'b1), "word");
      check("alert", {15'h0, alert_oe_n}, 16'h0001);
      fault_cond = 5'b00001;
      idle(5);
      wr(8'h03, 8'h00);
      idle(2);
      rd(8'h78, 16'h0002, "byte");
      check("alert", {15'h0, alert_oe_n}, 16'h0000);
      fault_cond = 5'h00;
      idle(3);
      wr(8'h03, 8'h00);
      rd(8'h78, 16'h0000, "byte");
      wr(8'h55, 8'h5a);
      rd(8'h78, 16'h0002, "byte");
      wr(8'h03, 8'h00);
      fault_cond = 5'b10000;
      idle(5);
      check("conv_enable", {15'h0, conv_enable}, 16'h0000);
      check("alert_out", {15'h0, alert_out}, 16'h0000);
      fault_cond = 5'h00;
      idle(3);
      wr(8'h03, 8'h00);
      idle(5);
      check("conv_enable", {15'h0, conv_enable}, 16'h0000);
      rd(8'h79, stat(5'h00, 1'b0), "word");
      fault_cond = 5'b00100;
      idle(5);
      fault_cond = 5'h00;
      en_pin = 1'b0;
      idle(5);
      en_pin = 1'b1;
      idle(5);
      check("conv_enable", {15'h0, conv_enable}, 16'h0001);
      rd(8'h79, stat(5'h00, 1'b1), "word");
      wr(8'h02, 8'h08);
      wr(8'h11, 8'h00);
      check("busy", {15'h0, rsp.busy}, 16'h0001);
      wr(8'h02, 8'h04);
      rd(8'h02, 16'h0017, "config");
      wr(8'h12, 8'h00);
      rd(8'h02, 16'h001b, "config");
      print_verdict();
   end
endmodule // test_pmbus_onoff_protect_fault_status
